/* src/csi_map.svh */
// Constants for the contactor sequencer and interlock monitor
`ifndef CSI_MAP_SVH
`define CSI_MAP_SVH
`define CSI_CLK_HZ 25000000
`define CSI_IL_FREQ_HZ 33
`define CSI_IL_PERIOD_CYC (`CSI_CLK_HZ / `CSI_IL_FREQ_HZ)
`define CSI_IL_HALF_CYC (`CSI_IL_PERIOD_CYC / 2)
`define CSI_IL_TOL_CYC 2
`define CSI_PICKUP_MS 200
`define CSI_PICKUP_CYC ((`CSI_CLK_HZ / 1000) * `CSI_PICKUP_MS)
`define CSI_STEP_TIMEOUT_CYC 4000
`define CSI_DUTY_ZERO 8'h00
`define CSI_DUTY_FULL 8'hff
`define CSI_HB_CFG_WORD 16'he9b8
`define CSI_HIST_DEPTH 4
`endif

/* src/csi_period_hist.sv */
// Small register store of the last measured interlock periods
`timescale 1ns/1ns
`default_nettype none
`include "csi_map.svh"
module csi_period_hist (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Write side
    input wire logic wr_en,
    input wire logic [1:0] wr_addr,
    input wire logic [19:0] wr_data,
    // Read side
    input wire logic [1:0] rd_addr,
    output logic [19:0] rd_data
);
    logic [19:0] mem [0:`CSI_HIST_DEPTH-1];
    logic [19:0] next_rd_data;

    always_comb begin
        next_rd_data = mem[rd_addr];
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data <= 20'h00000;
            for (int i = 0; i < `CSI_HIST_DEPTH; i++) begin
                mem[i] <= 20'h00000;
            end
        end else if (clk_en) begin
            rd_data <= next_rd_data;
            if (wr_en) begin
                mem[wr_addr] <= wr_data;
            end
        end
    end
endmodule
`default_nettype wire

/* src/csi_pkg.sv */
// Types for the contactor sequencer and interlock monitor
`default_nettype none
package csi_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_MODE = 4'h1,
        ST_ZERO = 4'h2,
        ST_SUPPLY = 4'h3,
        ST_RELEASE = 4'h4,
        ST_ENABLE = 4'h5,
        ST_CONFIG = 4'h6,
        ST_PICKUP = 4'h7,
        ST_HOLD = 4'h8,
        ST_OPEN_EN = 4'h9,
        ST_OPEN_PWM = 4'ha
    } csi_state_t;

    typedef enum logic [1:0] {
        IL_UNKNOWN = 2'h0,
        IL_HEALTHY = 2'h1,
        IL_SHORT_SUPPLY = 2'h2,
        IL_LOW_OR_OPEN = 2'h3
    } csi_il_state_t;

    typedef struct packed {
        logic cfg_start;
        logic [15:0] cfg_word;
        logic [7:0] sel_chan;
        logic sel_start;
    } csi_spi_req_t;

    typedef struct packed {
        logic busy;
        logic done;
        logic status_ok;
    } csi_spi_rsp_t;
endpackage
`default_nettype wire

/* src/csi_top.sv */
// Contactor close/open sequencer and interlock loop monitor
`timescale 1ns/1ns
`default_nettype none
`include "csi_map.svh"
module csi_top #(
    parameter int PICKUP_CYC = `CSI_PICKUP_CYC,
    parameter int IL_PERIOD_CYC = `CSI_IL_PERIOD_CYC,
    parameter int STEP_TIMEOUT = `CSI_STEP_TIMEOUT_CYC
) (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Commands
    input wire logic close_req,
    input wire logic open_req,
    input wire logic [7:0] sel_chan,
    input wire logic sel_req,
    // Supervisor and supply status
    input wire logic supervisor_normal,
    input wire logic driver_supply_output,
    input wire logic safety_out_first_n,
    input wire logic safety_out_second_n,
    // Supervisor controls
    output logic safety_release_req,
    output logic driver_enable_line_a,
    output logic driver_enable_line_b,
    output logic driver_enable,
    // SPI engine handshake
    output csi_pkg::csi_spi_req_t spi_req,
    input wire csi_pkg::csi_spi_rsp_t spi_rsp,
    // Coil drive
    input wire logic [7:0] reg_duty,
    output logic [7:0] pwm_duty,
    output logic [7:0] coil_duty,
    // Interlock loop
    output logic il_tx,
    input wire logic il_rx,
    output csi_pkg::csi_il_state_t il_state,
    // Status
    output csi_pkg::csi_state_t seq_state,
    output logic contactor_closed,
    output logic seq_error,
    output logic [19:0] last_period
);
    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    csi_pkg::csi_state_t next_seq_state;
    logic [23:0] tmr, next_tmr;
    logic [7:0] next_pwm_duty;
    logic next_en_a, next_en_b, next_release, next_error, next_cfg_start;
    logic timeout;
    logic cfg_start_q;

    function automatic logic [23:0] to24(input int v);
        to24 = v[23:0];
    endfunction

    assign timeout = tmr >= to24(STEP_TIMEOUT);

    always_comb begin
        next_seq_state = seq_state;
        next_tmr = tmr + 24'h000001;
        next_pwm_duty = pwm_duty;
        next_en_a = driver_enable_line_a;
        next_en_b = driver_enable_line_b;
        next_release = safety_release_req;
        next_error = seq_error;
        next_cfg_start = 1'b0;
        case (seq_state)
            csi_pkg::ST_IDLE: begin
                next_tmr = 24'h000000;
                if (close_req) begin
                    next_seq_state = csi_pkg::ST_MODE;
                    next_error = 1'b0;
                end
            end
            csi_pkg::ST_MODE: begin
                if (supervisor_normal) begin
                    next_seq_state = csi_pkg::ST_ZERO;
                    next_tmr = 24'h000000;
                end
            end
            csi_pkg::ST_ZERO: begin
                next_pwm_duty = `CSI_DUTY_ZERO;
                next_seq_state = csi_pkg::ST_SUPPLY;
                next_tmr = 24'h000000;
            end
            csi_pkg::ST_SUPPLY: begin
                if (driver_supply_output) begin
                    next_seq_state = csi_pkg::ST_RELEASE;
                    next_release = 1'b1;
                    next_tmr = 24'h000000;
                end
            end
            csi_pkg::ST_RELEASE: begin
                if (safety_out_first_n && safety_out_second_n) begin
                    next_seq_state = csi_pkg::ST_ENABLE;
                    next_tmr = 24'h000000;
                end
            end
            csi_pkg::ST_ENABLE: begin
                next_en_a = 1'b1;
                next_en_b = 1'b1;
                next_cfg_start = 1'b1;
                next_seq_state = csi_pkg::ST_CONFIG;
                next_tmr = 24'h000000;
            end
            csi_pkg::ST_CONFIG: begin
                if (spi_rsp.done) begin
                    next_tmr = 24'h000000;
                    if (spi_rsp.status_ok) begin
                        next_pwm_duty = `CSI_DUTY_FULL;
                        next_seq_state = csi_pkg::ST_PICKUP;
                    end else begin
                        next_error = 1'b1;
                        next_seq_state = csi_pkg::ST_OPEN_EN;
                    end
                end
            end
            csi_pkg::ST_PICKUP: begin
                if (tmr >= to24(PICKUP_CYC - 1)) begin
                    next_seq_state = csi_pkg::ST_HOLD;
                end
            end
            csi_pkg::ST_HOLD: begin
                next_tmr = 24'h000000;
                next_pwm_duty = reg_duty;
            end
            csi_pkg::ST_OPEN_EN: begin
                next_en_a = 1'b0;
                next_en_b = 1'b0;
                next_seq_state = csi_pkg::ST_OPEN_PWM;
            end
            csi_pkg::ST_OPEN_PWM: begin
                next_pwm_duty = `CSI_DUTY_ZERO;
                next_release = 1'b0;
                next_seq_state = csi_pkg::ST_IDLE;
            end
            default: next_seq_state = csi_pkg::ST_IDLE;
        endcase
        if (seq_state inside {csi_pkg::ST_MODE, csi_pkg::ST_SUPPLY, csi_pkg::ST_RELEASE,
                csi_pkg::ST_CONFIG} && timeout) begin
            next_error = 1'b1;
            next_seq_state = csi_pkg::ST_OPEN_EN;
        end
        if (open_req && seq_state != csi_pkg::ST_IDLE && seq_state != csi_pkg::ST_OPEN_EN
                && seq_state != csi_pkg::ST_OPEN_PWM) begin
            next_seq_state = csi_pkg::ST_OPEN_EN;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            seq_state <= csi_pkg::ST_IDLE;
            tmr <= 24'h000000;
            pwm_duty <= `CSI_DUTY_ZERO;
            driver_enable_line_a <= 1'b0;
            driver_enable_line_b <= 1'b0;
            safety_release_req <= 1'b0;
            seq_error <= 1'b0;
            cfg_start_q <= 1'b0;
        end else if (clk_en) begin
            seq_state <= next_seq_state;
            tmr <= next_tmr;
            pwm_duty <= next_pwm_duty;
            driver_enable_line_a <= next_en_a;
            driver_enable_line_b <= next_en_b;
            safety_release_req <= next_release;
            seq_error <= next_error;
            cfg_start_q <= next_cfg_start;
        end
    end

    // Selector requests pass while the SPI engine does not report busy
    logic sel_start_q, next_sel_start;
    logic [7:0] sel_chan_q, next_sel_chan;

    always_comb begin
        next_sel_start = sel_req && !spi_rsp.busy;
        next_sel_chan = sel_req ? sel_chan : sel_chan_q;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sel_start_q <= 1'b0;
            sel_chan_q <= 8'h00;
        end else if (clk_en) begin
            sel_start_q <= next_sel_start;
            sel_chan_q <= next_sel_chan;
        end
    end
    assign spi_req = '{cfg_start: cfg_start_q, cfg_word: `CSI_HB_CFG_WORD,
        sel_chan: sel_chan_q, sel_start: sel_start_q};

    // ------------------------------------------------------------
    // Coil and enable gating
    // ------------------------------------------------------------
    assign coil_duty = !safety_out_first_n ? `CSI_DUTY_FULL : pwm_duty;
    assign driver_enable = (driver_enable_line_a || driver_enable_line_b)
        && safety_out_second_n;
    assign contactor_closed = seq_state == csi_pkg::ST_HOLD;

    // ------------------------------------------------------------
    // Interlock transmitter and receiver
    // ------------------------------------------------------------
    logic [19:0] tx_cnt, next_tx_cnt, rx_cnt, next_rx_cnt, rise_cnt, next_rise_cnt;
    logic next_il_tx, rx_d, next_rx_d, rise;
    logic [1:0] wr_ptr, next_wr_ptr;
    csi_pkg::csi_il_state_t next_il_state;

    function automatic logic [19:0] to20(input int v);
        to20 = v[19:0];
    endfunction

    assign rise = il_rx && !rx_d;

    always_comb begin
        next_tx_cnt = tx_cnt + 20'h00001;
        next_il_tx = il_tx;
        if (tx_cnt == to20(IL_PERIOD_CYC / 2 - 1)) begin
            next_il_tx = 1'b0;
        end
        if (tx_cnt == to20(IL_PERIOD_CYC - 1)) begin
            next_tx_cnt = 20'h00000;
            next_il_tx = 1'b1;
        end
        next_rx_d = il_rx;
        next_rx_cnt = (il_rx != rx_d) ? 20'h00000 : rx_cnt + 20'h00001;
        next_wr_ptr = wr_ptr;
        next_il_state = il_state;
        // Cycles since the last rise, saturating
        next_rise_cnt = (rise_cnt == 20'hfffff) ? rise_cnt : rise_cnt + 20'h00001;
        if (rise) begin
            next_rise_cnt = 20'h00001;
            next_wr_ptr = wr_ptr + 2'h1;
            // Period since last rise must match, rise must align with ours
            if (rise_cnt >= to20(IL_PERIOD_CYC - `CSI_IL_TOL_CYC)
                    && rise_cnt <= to20(IL_PERIOD_CYC + `CSI_IL_TOL_CYC)
                    && (tx_cnt <= to20(`CSI_IL_TOL_CYC)
                    || tx_cnt >= to20(IL_PERIOD_CYC - `CSI_IL_TOL_CYC))) begin
                next_il_state = csi_pkg::IL_HEALTHY;
            end else begin
                next_il_state = csi_pkg::IL_UNKNOWN;
            end
        end
        // Saturate only while the level holds, so a returning edge can recover
        if (il_rx == rx_d && rx_cnt > to20(IL_PERIOD_CYC)) begin
            next_rx_cnt = rx_cnt;
            next_il_state = il_rx ? csi_pkg::IL_SHORT_SUPPLY
                                  : csi_pkg::IL_LOW_OR_OPEN;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_cnt <= 20'h00000;
            il_tx <= 1'b1;
            rx_cnt <= 20'h00000;
            rx_d <= 1'b0;
            wr_ptr <= 2'h0;
            il_state <= csi_pkg::IL_UNKNOWN;
            rise_cnt <= 20'h00000;
        end else if (clk_en) begin
            tx_cnt <= next_tx_cnt;
            il_tx <= next_il_tx;
            rx_cnt <= next_rx_cnt;
            rx_d <= next_rx_d;
            wr_ptr <= next_wr_ptr;
            il_state <= next_il_state;
            rise_cnt <= next_rise_cnt;
        end
    end

    csi_period_hist u_hist (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .wr_en(rise),
        .wr_addr(wr_ptr),
        .wr_data(rise_cnt),
        .rd_addr(wr_ptr - 2'h1),
        .rd_data(last_period)
    );

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_enable_step;
        seq_state == csi_pkg::ST_ENABLE && clk_en;
    endsequence

    property p_no_early_cfg;
        @(posedge core_clk) disable iff (sys_rst)
        spi_req.cfg_start |-> driver_enable_line_a && driver_enable_line_b;
    endproperty
    a_no_early_cfg: assert property (p_no_early_cfg) else $error("config before enable");

    property p_mode_gate;
        @(posedge core_clk) disable iff (sys_rst)
        seq_state == csi_pkg::ST_MODE && !supervisor_normal && !open_req && !timeout && clk_en
        |=> seq_state == csi_pkg::ST_MODE;
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("advanced without normal mode");

    property p_zero_before_enable;
        @(posedge core_clk) disable iff (sys_rst)
        $rose(driver_enable_line_a) && seq_state == csi_pkg::ST_CONFIG
        |-> pwm_duty == `CSI_DUTY_ZERO;
    endproperty
    a_zero_before_enable: assert property (p_zero_before_enable) else $error("duty not zero");

    property p_supply_gate;
        @(posedge core_clk) disable iff (sys_rst)
        $rose(safety_release_req) |-> $past(driver_supply_output);
    endproperty
    a_supply_gate: assert property (p_supply_gate) else $error("release without supply");

    property p_enable_after_release;
        @(posedge core_clk) disable iff (sys_rst)
        s_enable_step |=> driver_enable_line_a && driver_enable_line_b && safety_release_req;
    endproperty
    a_enable_after_release: assert property (p_enable_after_release) else $error("enable bad");

    property p_pickup_full;
        @(posedge core_clk) disable iff (sys_rst)
        seq_state == csi_pkg::ST_PICKUP |-> pwm_duty == `CSI_DUTY_FULL;
    endproperty
    a_pickup_full: assert property (p_pickup_full) else $error("pick-up not full duty");

    property p_open_order;
        @(posedge core_clk) disable iff (sys_rst)
        seq_state == csi_pkg::ST_OPEN_EN && clk_en
        |=> !driver_enable_line_a && !driver_enable_line_b && seq_state == csi_pkg::ST_OPEN_PWM;
    endproperty
    a_open_order: assert property (p_open_order) else $error("opening order wrong");

    property p_force_full;
        @(posedge core_clk) disable iff (sys_rst)
        !safety_out_first_n |-> coil_duty == `CSI_DUTY_FULL;
    endproperty
    a_force_full: assert property (p_force_full) else $error("coil not forced full");

    property p_second_off;
        @(posedge core_clk) disable iff (sys_rst)
        !safety_out_second_n |-> !driver_enable;
    endproperty
    a_second_off: assert property (p_second_off) else $error("drivers not disabled");
endmodule
`default_nettype wire

/* testbench/csi_partner.sv */
// Far-side model: supervisor safety outputs, SPI engine and interlock loop
`timescale 1ns/1ns
`default_nettype none
module csi_partner (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Scenario controls
    input wire logic spi_good,
    input wire logic fault_first,
    input wire logic fault_second,
    input wire logic [1:0] il_mode,
    // Block side
    input wire csi_pkg::csi_spi_req_t spi_req,
    output var csi_pkg::csi_spi_rsp_t spi_rsp,
    input wire logic driver_enable,
    input wire logic safety_release_req,
    output logic safety_out_first_n,
    output logic safety_out_second_n,
    input wire logic il_tx,
    output logic il_rx
);
    logic [2:0] cnt;
    logic released;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= 3'h0;
            spi_rsp <= '0;
            released <= 1'b0;
            il_rx <= 1'b0;
        end else begin
            // Status means something only with done; otherwise it shows the opposite
            spi_rsp.done <= (cnt == 3'h1);
            spi_rsp.status_ok <= (cnt == 3'h1) ? spi_good : ~spi_good;
            // Bridge drivers stay silent until enabled
            if ((spi_req.cfg_start && driver_enable) || spi_req.sel_start) begin
                cnt <= 3'h4;
                spi_rsp.busy <= 1'b1;
            end else if (cnt != 3'h0) begin
                cnt <= cnt - 3'h1;
                spi_rsp.busy <= (cnt != 3'h1);
            end
            released <= safety_release_req;
            il_rx <= (il_mode == 2'h0) ? il_tx : (il_mode == 2'h1);
        end
    end
    // Injected faults pull the safety outputs low
    assign safety_out_first_n = released & ~fault_first;
    assign safety_out_second_n = released & ~fault_second;
endmodule
`default_nettype wire

/* testbench/tb_contactor_sequencer_interlock.sv */
// Self-checking bench for the contactor sequencer and interlock monitor
`timescale 1ns/1ns
`default_nettype none
module tb_contactor_sequencer_interlock;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic close_req = 1'b0;
    logic open_req = 1'b0;
    logic sel_req = 1'b0;
    logic [7:0] sel_chan = 8'h00;
    logic [7:0] reg_duty = 8'h3c;
    logic supervisor_normal = 1'b0;
    logic driver_supply_output = 1'b0;
    logic spi_good = 1'b1;
    logic fault_first = 1'b0;
    logic fault_second = 1'b0;
    logic [1:0] il_mode = 2'h0;
    logic safety_release_req, line_a, line_b, driver_enable, il_tx, il_rx;
    logic safety_out_first_n, safety_out_second_n, contactor_closed, seq_error;
    logic [7:0] pwm_duty, coil_duty;
    logic [19:0] last_period;
    csi_pkg::csi_spi_req_t spi_req;
    csi_pkg::csi_spi_rsp_t spi_rsp;
    csi_pkg::csi_il_state_t il_state;
    csi_pkg::csi_state_t seq_state;
    int errors = 0;
    int checks_done = 0;
    int n;
    csi_top #(.PICKUP_CYC(50), .IL_PERIOD_CYC(100), .STEP_TIMEOUT(40)) i_dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .close_req(close_req), .open_req(open_req), .sel_chan(sel_chan), .sel_req(sel_req),
        .supervisor_normal(supervisor_normal), .driver_supply_output(driver_supply_output),
        .safety_out_first_n(safety_out_first_n), .safety_out_second_n(safety_out_second_n),
        .safety_release_req(safety_release_req), .driver_enable_line_a(line_a),
        .driver_enable_line_b(line_b), .driver_enable(driver_enable),
        .spi_req(spi_req), .spi_rsp(spi_rsp), .reg_duty(reg_duty), .pwm_duty(pwm_duty),
        .coil_duty(coil_duty), .il_tx(il_tx), .il_rx(il_rx), .il_state(il_state),
        .seq_state(seq_state), .contactor_closed(contactor_closed), .seq_error(seq_error),
        .last_period(last_period)
    );
    csi_partner i_partner (
        .core_clk(core_clk), .sys_rst(sys_rst), .spi_good(spi_good),
        .fault_first(fault_first), .fault_second(fault_second), .il_mode(il_mode),
        .spi_req(spi_req), .spi_rsp(spi_rsp), .driver_enable(driver_enable),
        .safety_release_req(safety_release_req), .safety_out_first_n(safety_out_first_n),
        .safety_out_second_n(safety_out_second_n), .il_tx(il_tx), .il_rx(il_rx)
    );
    initial begin
        forever #20 core_clk = ~core_clk;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task wrap_up();
        $display("Checks %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task chk(input string what, input logic [19:0] exp, input logic [19:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            errors++;
        end
    endtask
    task step(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    task wait_st(input csi_pkg::csi_state_t s, input int lim);
        n = 0;
        while (seq_state !== s && n < lim) begin
            step(1);
            n++;
        end
        if (seq_state !== s) begin
            $display("Error wait for state %h expected reached seen %h", s, seq_state);
            errors++;
            wrap_up();
        end
    endtask
    task pulse_close();
        @(posedge core_clk);
        close_req <= 1'b1;
        @(posedge core_clk);
        close_req <= 1'b0;
        #1;
    endtask
    task rise_tx();
        logic p;
        n = 0;
        p = il_tx;
        step(1);
        while (!(il_tx === 1'b1 && p === 1'b0) && n < 300) begin
            p = il_tx;
            step(1);
            n++;
        end
        if (n >= 300) begin
            $display("Error il_tx rise expected seen none");
            errors++;
            wrap_up();
        end
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        pulse_close();
        wait_st(csi_pkg::ST_MODE, 10);
        step(8);
        chk("state without normal mode", csi_pkg::ST_MODE, seq_state);
        wait_st(csi_pkg::ST_IDLE, 100);
        chk("mode timeout error", 1'b1, seq_error);
        $display("Test mode refusal done");
        @(posedge core_clk);
        supervisor_normal <= 1'b1;
        pulse_close();
        wait_st(csi_pkg::ST_SUPPLY, 10);
        chk("duty before release", 8'h00, pwm_duty);
        step(6);
        chk("state without supply", csi_pkg::ST_SUPPLY, seq_state);
        chk("release before supply", 1'b0, safety_release_req);
        chk("cfg before enable", 1'b0, spi_req.cfg_start);
        chk("lines before release", 1'b0, line_a | line_b);
        driver_supply_output <= 1'b1;
        wait_st(csi_pkg::ST_ENABLE, 20);
        chk("safety outputs released", 2'h3, {safety_out_first_n, safety_out_second_n});
        wait_st(csi_pkg::ST_CONFIG, 5);
        chk("enable lines", 2'h3, {line_a, line_b});
        chk("driver enable or", 1'b1, driver_enable);
        chk("duty during config", 8'h00, pwm_duty);
        wait_st(csi_pkg::ST_PICKUP, 20);
        chk("pick-up duty", 8'hff, pwm_duty);
        n = 0;
        while (seq_state === csi_pkg::ST_PICKUP && n < 200) begin
            step(1);
            n++;
        end
        chk("pick-up cycles", 20'd50, n[19:0]);
        chk("state after pick-up", csi_pkg::ST_HOLD, seq_state);
        step(2);
        chk("hold duty", reg_duty, pwm_duty);
        chk("closed flag", 1'b1, contactor_closed);
        chk("error cleared", 1'b0, seq_error);
        $display("Test close done");
        fault_first <= 1'b1;
        step(1);
        chk("forced coil duty", 8'hff, coil_duty);
        chk("controller duty kept", 8'h3c, pwm_duty);
        fault_second <= 1'b1;
        step(1);
        chk("enable on second fault", 1'b0, driver_enable);
        fault_first <= 1'b0;
        fault_second <= 1'b0;
        step(1);
        chk("coil duty restored", 8'h3c, coil_duty);
        $display("Test fault override done");
        @(posedge core_clk);
        open_req <= 1'b1;
        @(posedge core_clk);
        open_req <= 1'b0;
        #1;
        wait_st(csi_pkg::ST_OPEN_EN, 5);
        wait_st(csi_pkg::ST_OPEN_PWM, 3);
        chk("lines cleared first", 2'h0, {line_a, line_b});
        chk("duty not yet zero", 8'h3c, pwm_duty);
        wait_st(csi_pkg::ST_IDLE, 3);
        chk("duty zero after open", 8'h00, pwm_duty);
        $display("Test open done");
        spi_good <= 1'b0;
        pulse_close();
        wait_st(csi_pkg::ST_CONFIG, 40);
        wait_st(csi_pkg::ST_IDLE, 100);
        chk("bad status error", 1'b1, seq_error);
        chk("no pick-up on bad status", 8'h00, pwm_duty);
        chk("lines dropped on abort", 2'h0, {line_a, line_b});
        $display("Test bad status done");
        @(posedge core_clk);
        sel_chan <= 8'h15;
        sel_req <= 1'b1;
        @(posedge core_clk);
        sel_req <= 1'b0;
        #1;
        chk("selector start", 1'b1, spi_req.sel_start);
        chk("selector channel", 8'h15, spi_req.sel_chan);
        chk("config word", 16'he9b8, spi_req.cfg_word);
        $display("Test selector done");
        rise_tx();
        rise_tx();
        chk("tx period", 20'd100, n[19:0] + 20'd1);
        chk("loop healthy", csi_pkg::IL_HEALTHY, il_state);
        chk("measured period", 20'd100, last_period);
        @(posedge core_clk);
        il_mode <= 2'h1;
        step(80);
        chk("no early fault", 1'b0, il_state === csi_pkg::IL_SHORT_SUPPLY);
        step(80);
        chk("short to supply", csi_pkg::IL_SHORT_SUPPLY, il_state);
        il_mode <= 2'h2;
        step(80);
        chk("no early low fault", csi_pkg::IL_SHORT_SUPPLY, il_state);
        step(140);
        chk("low or open", csi_pkg::IL_LOW_OR_OPEN, il_state);
        il_mode <= 2'h0;
        step(300);
        chk("loop recovered", csi_pkg::IL_HEALTHY, il_state);
        $display("Test interlock done");
        wrap_up();
    end
endmodule
`default_nettype wire
